// file: rpms_defs.svh
`ifndef RPMS_DEFS_SVH
`define RPMS_DEFS_SVH

// Register byte offsets
`define RPMS_CTRL_OFS        8'h00
`define RPMS_STAT_OFS        8'h04

// Control field positions
`define RPMS_SWRST_BIT       0
`define RPMS_TSD_LSB         1
`define RPMS_SSD_BIT         5
`define RPMS_TTR_BIT         6
`define RPMS_PTR_BIT         7

// Reset values
`define RPMS_CTRL_RST        8'h00

// Reset stretch counts
`define RPMS_POR_OSC_CYC     7'd64
`define RPMS_CG_OSC_CYC      6'd32
`define RPMS_PR_SYS_CYC      6'd32
`define RPMS_CR_SYS_CYC      6'd32

// Watchdog clock divider
`define RPMS_WDOG_DIV        11'd1024

`endif

// file: rpms_pkg.sv
package rpms_pkg;

  typedef enum logic [2:0] {
    RPMS_RUN   = 3'b000,
    RPMS_WAIT  = 3'b001,
    RPMS_STOP  = 3'b010,
    RPMS_PDOWN = 3'b011
  } rpms_mode_t;

  // Software controls
  typedef struct packed {
    logic       pwm_triple_rate;
    logic       timer_triple_rate;
    logic       serial_stop_disable;
    logic [3:0] timer_stop_disable;
  } rpms_ctrl_t;

  // Staged reset outputs, active low
  typedef struct packed {
    logic extended_por_n;
    logic clock_generator_reset_n;
    logic peripheral_reset_n;
    logic core_reset_n;
    logic jtag_reset_n;
  } rpms_resets_t;

  // Clock gate enables
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic timer_hs_clk_en;
    logic pwm_hs_clk_en;
    logic system_bus_clk_en;
    logic watchdog_tick;
  } rpms_gates_t;

  typedef struct packed {
    rpms_mode_t   mode;
    rpms_ctrl_t   ctrl;
    rpms_resets_t rst;
    rpms_gates_t  gate;
    logic         sw_reset;
    logic [6:0]   por_cnt;
    logic [5:0]   cg_cnt;
    logic [5:0]   pr_cnt;
    logic [5:0]   cr_cnt;
    logic [9:0]   wd_cnt;
    logic         osc_q;
    logic         dbl_q;
    logic         div2;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } rpms_state_t;

endpackage : rpms_pkg

// file: rpms_top.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
`include "rpms_defs.svh"

module rpms_top
  import rpms_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        external_reset_n,
  input  wire logic        watchdog_reset,
  input  wire logic        master_osc_clock,
  input  wire logic        double_rate_system_clock,
  input  wire logic        pll_source_select,
  input  wire logic        pll_power_down,
  input  wire logic        oscillator_source_select,
  input  wire logic        oscillator_standby,
  input  wire logic        oscillator_power_down,
  input  wire logic        regulator_standby,
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        any_irq,
  input  wire logic [3:0]  timer_irq,
  input  wire logic        serial_irq,
  input  wire logic        low_voltage_irq,
  input  wire logic        debug_entry,
  output logic             extended_por_n,
  output logic             clock_generator_reset_n,
  output logic             peripheral_reset_n,
  output logic             core_reset_n,
  output logic             jtag_reset_n,
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic [3:0]       timer_clk_en,
  output logic             serial_clk_en,
  output logic             timer_hs_clk_en,
  output logic             pwm_hs_clk_en,
  output logic             system_bus_clk_en,
  output logic             watchdog_tick,
  output logic             standby_active,
  output logic             regulator_standby_ok
);

  rpms_state_t s;
  rpms_state_t next_s;

  logic [3:0]  next_timer_clk_en;
  logic        next_serial_clk_en;
  logic [3:0]  timer_clk_q;
  logic        serial_clk_q;
  logic        standby_q;
  logic        reg_ok_q;

  // Register read mux
  function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                         input rpms_state_t st,
                                         input logic stby);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `RPMS_CTRL_OFS: begin
        d[`RPMS_TSD_LSB +: 4] = st.ctrl.timer_stop_disable;
        d[`RPMS_SSD_BIT]      = st.ctrl.serial_stop_disable;
        d[`RPMS_TTR_BIT]      = st.ctrl.timer_triple_rate;
        d[`RPMS_PTR_BIT]      = st.ctrl.pwm_triple_rate;
      end
      `RPMS_STAT_OFS: begin
        d[2:0] = st.mode;
        d[3]   = stby;
        d[4]   = st.rst.extended_por_n;
        d[5]   = st.rst.clock_generator_reset_n;
        d[6]   = st.rst.peripheral_reset_n;
        d[7]   = st.rst.core_reset_n;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  logic osc_rise;
  logic osc_fall;
  logic dbl_rise;
  logic any_src;
  logic standby;
  logic stop_wake;
  logic pll_run;
  logic clocks_on;
  logic core_on;
  logic apb_acc;
  logic mapped;

  always_comb begin
    // Oscillator and double-rate edges, inputs sampled synchronously
    osc_rise = master_osc_clock & ~s.osc_q;
    osc_fall = ~master_osc_clock & s.osc_q;
    dbl_rise = double_rate_system_clock & ~s.dbl_q;
    // external pin, software write and watchdog sources
    any_src  = ~external_reset_n | s.sw_reset | watchdog_reset;
    // standby is the software-built low-speed configuration
    standby  = oscillator_source_select & pll_power_down &
               oscillator_standby;
    stop_wake = |(timer_irq & s.ctrl.timer_stop_disable) |
                (serial_irq & s.ctrl.serial_stop_disable) |
                low_voltage_irq | debug_entry;
    pll_run  = pll_source_select & ~pll_power_down;
    apb_acc  = psel & penable & ~s.pready;
    mapped   = (paddr == `RPMS_CTRL_OFS) | (paddr == `RPMS_STAT_OFS);

    next_s = s;
    next_s.osc_q    = master_osc_clock;
    next_s.dbl_q    = double_rate_system_clock;
    next_s.sw_reset = 1'b0;

    // APB slave, answers one cycle after the access phase starts
    next_s.pready  = apb_acc;
    next_s.pslverr = apb_acc & ~mapped;
    next_s.prdata  = s.prdata;
    if (apb_acc && !pwrite) begin
      next_s.prdata = rd_mux(paddr, s, standby_q);
    end
    if (apb_acc && pwrite && paddr == `RPMS_CTRL_OFS) begin
      next_s.ctrl.timer_stop_disable  = pwdata[`RPMS_TSD_LSB +: 4];
      next_s.ctrl.serial_stop_disable = pwdata[`RPMS_SSD_BIT];
      next_s.ctrl.timer_triple_rate   = pwdata[`RPMS_TTR_BIT];
      next_s.ctrl.pwm_triple_rate     = pwdata[`RPMS_PTR_BIT];
      next_s.sw_reset = pwdata[`RPMS_SWRST_BIT];
    end

    // JTAG reset follows power-on reset only
    next_s.rst.jtag_reset_n = 1'b1;

    // stretch POR by 64 oscillator cycles
    if (!s.rst.extended_por_n && osc_rise) begin
      next_s.por_cnt = s.por_cnt + 7'd1;
      if (s.por_cnt == `RPMS_POR_OSC_CYC - 7'd1) begin
        next_s.rst.extended_por_n = 1'b1;
      end
    end

    // clockgen release, 32 osc cycles, on osc fall
    if (any_src || !s.rst.extended_por_n) begin
      next_s.cg_cnt = 6'd0;
      next_s.rst.clock_generator_reset_n = 1'b0;
    end else if (!s.rst.clock_generator_reset_n) begin
      if (s.cg_cnt != `RPMS_CG_OSC_CYC && osc_rise) begin
        next_s.cg_cnt = s.cg_cnt + 6'd1;
      end
      if (s.cg_cnt == `RPMS_CG_OSC_CYC && osc_fall) begin
        next_s.rst.clock_generator_reset_n = 1'b1;
      end
    end

    // peripheral reset 32 bus cycles after clockgen
    if (!s.rst.clock_generator_reset_n || any_src) begin
      next_s.pr_cnt = 6'd0;
      next_s.rst.peripheral_reset_n = 1'b0;
    end else if (!s.rst.peripheral_reset_n) begin
      next_s.pr_cnt = s.pr_cnt + 6'd1;
      if (s.pr_cnt == `RPMS_PR_SYS_CYC - 6'd1) begin
        next_s.rst.peripheral_reset_n = 1'b1;
      end
    end

    // core reset 32 bus cycles after peripheral
    if (!s.rst.peripheral_reset_n || any_src) begin
      next_s.cr_cnt = 6'd0;
      next_s.rst.core_reset_n = 1'b0;
    end else if (!s.rst.core_reset_n) begin
      next_s.cr_cnt = s.cr_cnt + 6'd1;
      if (s.cr_cnt == `RPMS_CR_SYS_CYC - 6'd1) begin
        next_s.rst.core_reset_n = 1'b1;
      end
    end

    case (s.mode)
      RPMS_RUN: begin
        if (standby && oscillator_power_down) begin
          next_s.mode = RPMS_PDOWN;
        end else if (stop_exec) begin
          next_s.mode = RPMS_STOP;
        end else if (wait_exec) begin
          next_s.mode = RPMS_WAIT;
        end
      end
      RPMS_WAIT: begin
        // wait exit on interrupt or debug entry
        if (any_irq || debug_entry) begin
          next_s.mode = RPMS_RUN;
        end
      end
      RPMS_STOP: begin
        if (stop_wake) begin
          next_s.mode = RPMS_RUN;
        end
      end
      RPMS_PDOWN: begin
        // only pin or power-on reset leaves powerdown
        if (!external_reset_n) begin
          next_s.mode = RPMS_RUN;
        end
      end
      default: next_s.mode = RPMS_RUN;
    endcase
    // sync resets return to run, except from powerdown
    if ((s.sw_reset || watchdog_reset) && s.mode != RPMS_PDOWN) begin
      next_s.mode = RPMS_RUN;
    end
    if (!s.rst.peripheral_reset_n && s.mode != RPMS_PDOWN) begin
      next_s.mode = RPMS_RUN;
    end

    // bus clock enable every second double-rate edge
    if (dbl_rise) begin
      next_s.div2 = ~s.div2;
    end
    next_s.gate.system_bus_clk_en = dbl_rise & s.div2 &
                                    (next_s.mode != RPMS_PDOWN);

    // watchdog tick each 1024 oscillator cycles
    next_s.gate.watchdog_tick = 1'b0;
    if (osc_rise && s.mode != RPMS_PDOWN) begin
      next_s.wd_cnt = s.wd_cnt + 10'd1;
      if (s.wd_cnt == 10'(`RPMS_WDOG_DIV - 11'd1)) begin
        next_s.gate.watchdog_tick = 1'b1;
      end
    end

    // registered enables; wake restores clocks next edge
    clocks_on = (next_s.mode == RPMS_RUN) ||
                (next_s.mode == RPMS_WAIT);
    core_on   = (next_s.mode == RPMS_RUN);
    next_s.gate.core_clk_en   = core_on;
    next_s.gate.periph_clk_en = clocks_on;
    // triple rate only with PLL active and selected
    next_s.gate.timer_hs_clk_en = clocks_on & pll_run &
                                  s.ctrl.timer_triple_rate;
    next_s.gate.pwm_hs_clk_en   = clocks_on & pll_run &
                                  s.ctrl.pwm_triple_rate;

    // stop-disabled peripherals keep clocks in stop
    next_timer_clk_en = {4{clocks_on}} |
      ({4{next_s.mode == RPMS_STOP}} & s.ctrl.timer_stop_disable);
    next_serial_clk_en = clocks_on |
      ((next_s.mode == RPMS_STOP) & s.ctrl.serial_stop_disable);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s              <= '0;
      s.mode         <= RPMS_RUN;
      s.ctrl         <= rpms_ctrl_t'(`RPMS_CTRL_RST);
      timer_clk_q    <= 4'h0;
      serial_clk_q   <= 1'b0;
      standby_q      <= 1'b0;
      reg_ok_q       <= 1'b0;
    end else begin
      s              <= next_s;
      timer_clk_q    <= next_timer_clk_en;
      serial_clk_q   <= next_serial_clk_en;
      standby_q      <= standby;
      // regulator standby permitted when standby is active and PLL deselected
      reg_ok_q       <= ~pll_source_select & standby;
    end
  end

  // Outputs straight from flip-flops
  assign pready                  = s.pready;
  assign prdata                  = s.prdata;
  assign pslverr                 = s.pslverr;
  assign extended_por_n          = s.rst.extended_por_n;
  assign clock_generator_reset_n = s.rst.clock_generator_reset_n;
  assign peripheral_reset_n      = s.rst.peripheral_reset_n;
  assign core_reset_n            = s.rst.core_reset_n;
  assign jtag_reset_n            = s.rst.jtag_reset_n;
  assign core_clk_en             = s.gate.core_clk_en;
  assign periph_clk_en           = s.gate.periph_clk_en;
  assign timer_clk_en            = timer_clk_q;
  assign serial_clk_en           = serial_clk_q;
  assign timer_hs_clk_en         = s.gate.timer_hs_clk_en;
  assign pwm_hs_clk_en           = s.gate.pwm_hs_clk_en;
  assign system_bus_clk_en       = s.gate.system_bus_clk_en;
  assign watchdog_tick           = s.gate.watchdog_tick;
  assign standby_active          = standby_q;
  assign regulator_standby_ok    = reg_ok_q;

endmodule : rpms_top

// file: dummy_end_marker_not_used.sv
`timescale 1ns/1ns

// file: rpms_far.sv
`timescale 1ns/1ns
module rpms_far (
  input  wire logic pclk,
  input  wire logic stby_req,
  input  wire logic pdown_req,
  output logic      master_osc_clock,
  output logic      double_rate_system_clock,
  output logic      pll_source_select,
  output logic      pll_power_down,
  output logic      oscillator_source_select,
  output logic      oscillator_standby,
  output logic      oscillator_power_down,
  output logic      regulator_standby
);
  logic [1:0] osc_cnt = 2'h0;
  logic       dbl     = 1'b0;
  logic       osc_off = 1'b0;
  logic [2:0] step    = 3'h0;

  always @(posedge pclk) begin
    dbl <= ~dbl;
    if (!osc_off) osc_cnt <= osc_cnt + 2'h1;
    osc_off <= pdown_req && step == 3'h4;
    if (stby_req && step < 3'h4) step <= step + 3'h1;
    if (!stby_req && step > 3'h0) step <= step - 3'h1;
  end

  assign master_osc_clock         = osc_cnt[1];
  assign double_rate_system_clock = dbl;
  assign pll_source_select        = step == 3'h0;
  assign oscillator_source_select = step >= 3'h1;
  assign pll_power_down           = step >= 3'h2;
  assign oscillator_standby       = step >= 3'h3;
  assign regulator_standby        = step >= 3'h4;
  assign oscillator_power_down    = osc_off;
endmodule : rpms_far

// file: rpms_properties.sv
`timescale 1ns/1ns
module rpms_properties (
  input wire logic pclk, presetn, external_reset_n, watchdog_reset,
  input wire logic wait_exec, stop_exec, any_irq, debug_entry,
  input wire logic pll_source_select, pll_power_down, extended_por_n,
  input wire logic clock_generator_reset_n, peripheral_reset_n,
  input wire logic core_reset_n, jtag_reset_n, core_clk_en,
  input wire logic periph_clk_en, timer_hs_clk_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  jtag_hold_a: assert property (jtag_reset_n |=> jtag_reset_n)
    else $error("jtag reset reasserted");
  core_order_a: assert property (core_reset_n |-> peripheral_reset_n)
    else $error("core released before peripherals");
  per_order_a: assert property (peripheral_reset_n |-> clock_generator_reset_n)
    else $error("peripherals released before clockgen");
  cg_order_a: assert property (clock_generator_reset_n |-> extended_por_n)
    else $error("clockgen released before extended por");
  per_delay_a: assert property ($rose(clock_generator_reset_n) |->
    ##31 !peripheral_reset_n ##1 peripheral_reset_n)
    else $error("peripheral release delay wrong");
  core_delay_a: assert property ($rose(peripheral_reset_n) |->
    ##31 !core_reset_n ##1 core_reset_n)
    else $error("core release delay wrong");
  ext_reset_a: assert property (!external_reset_n |-> ##[1:3] !clock_generator_reset_n)
    else $error("external reset ignored");
  wdog_reset_a: assert property (watchdog_reset |-> ##[1:3] !peripheral_reset_n)
    else $error("watchdog reset ignored");
  wait_gate_a: assert property (wait_exec && core_clk_en && !stop_exec &&
    !any_irq && !debug_entry |-> ##[1:2] !core_clk_en)
    else $error("wait did not stop core clock");
  wait_wake_a: assert property (core_reset_n && !core_clk_en && periph_clk_en
    && (any_irq || debug_entry) |-> ##[1:2] core_clk_en)
    else $error("wait not left on wake");
  hs_gate_a: assert property (timer_hs_clk_en |->
    $past(pll_source_select) && !$past(pll_power_down))
    else $error("fast timer clock without pll");

  cover property ($rose(core_reset_n));
  cover property (wait_exec ##2 !core_clk_en);
  cover property (stop_exec ##2 !periph_clk_en);
endmodule : rpms_properties

bind rpms_top rpms_properties i_chk (.*);

// file: rpms_tb.sv
`timescale 1ns/1ns
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, stby_req = 0, pdown_req = 0;
  logic external_reset_n = 1, watchdog_reset = 0, wait_exec = 0;
  logic stop_exec = 0, any_irq = 0, serial_irq = 0, low_voltage_irq = 0;
  logic debug_entry = 0;
  logic [3:0] timer_irq = 4'h0, timer_clk_en;
  logic master_osc_clock, double_rate_system_clock, pll_source_select;
  logic pll_power_down, oscillator_source_select, oscillator_standby;
  logic oscillator_power_down, regulator_standby, extended_por_n;
  logic clock_generator_reset_n, peripheral_reset_n, core_reset_n;
  logic jtag_reset_n, core_clk_en, periph_clk_en, serial_clk_en;
  logic timer_hs_clk_en, pwm_hs_clk_en, system_bus_clk_en;
  logic watchdog_tick, standby_active, regulator_standby_ok;
  int fails = 0, check_count = 0, n, i, t0, t1, t2, m;

  rpms_top i_dut (.*);
  rpms_far i_far (.*);

  initial forever #25 pclk = ~pclk;

  task tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : tick

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk

  // One APB transfer, result left in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    tick(1);
  endtask : apb

  task wait_core;
    for (n = 0; n < 1000 && core_reset_n !== 1; n++) tick(1);
    chk(core_reset_n, 1);
  endtask : wait_core

  task stop_test;
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Hang guard
  initial begin
    #1000000;
    fails++;
    stop_test;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    for (n = 1; n < 900 && core_reset_n !== 1; n++) begin
      tick(1);
      if (extended_por_n !== 1) t0 = n;
      if (clock_generator_reset_n !== 1) t1 = n;
      if (peripheral_reset_n !== 1) t2 = n;
    end
    chk(t0 inside {[248:264]}, 1);
    chk((t1 - t0) inside {[126:134]}, 1);
    chk(t2 - t1, 32);
    chk(n - t2 - 2, 32);
    chk(jtag_reset_n, 1);
    apb(1, 8'h00, 32'h000000FE);
    apb(0, 8'h00, 32'h0);
    chk(rd, 32'h000000FE);
    apb(0, 8'h04, 32'h0);
    chk(rd, 32'h000000F0);
    apb(1, 8'h08, 32'h000000FF);
    chk(er, 1);
    chk({timer_hs_clk_en, pwm_hs_clk_en}, 2'h3);
    for (i = 0; i < 2; i++) begin
      wait_exec <= 1;
      tick(1);
      wait_exec <= 0;
      tick(2);
      chk({core_clk_en, periph_clk_en}, 2'h1);
      {debug_entry, any_irq} <= 2'h1 << i;
      tick(3);
      chk(core_clk_en, 1);
      {debug_entry, any_irq} <= 2'h0;
      tick(1);
    end
    for (i = 0; i < 4; i++) begin
      stop_exec <= 1;
      tick(1);
      stop_exec <= 0;
      any_irq <= 1;
      tick(3);
      chk({core_clk_en, periph_clk_en, serial_clk_en, timer_clk_en},
          7'h1F);
      {debug_entry, low_voltage_irq, serial_irq, timer_irq[0]} <= 4'h1 << i;
      tick(3);
      chk(core_clk_en, 1);
      {debug_entry, low_voltage_irq, serial_irq, timer_irq[0]} <= 4'h0;
      any_irq <= 0;
      tick(1);
    end
    stby_req <= 1;
    tick(8);
    chk({timer_hs_clk_en, standby_active, regulator_standby_ok}, 3'h3);
    apb(0, 8'h04, 32'h0);
    chk(rd, 32'h000000F8);
    wait_exec <= 1;
    tick(1);
    wait_exec <= 0;
    tick(2);
    chk({core_clk_en, periph_clk_en}, 2'h1);
    any_irq <= 1;
    tick(3);
    any_irq <= 0;
    pdown_req <= 1;
    tick(4);
    chk({core_clk_en, periph_clk_en}, 2'h0);
    any_irq <= 1;
    tick(4);
    chk(core_clk_en, 0);
    any_irq <= 0;
    external_reset_n <= 0;
    pdown_req <= 0;
    stby_req <= 0;
    tick(4);
    chk({jtag_reset_n, extended_por_n, core_reset_n}, 3'h6);
    external_reset_n <= 1;
    wait_core;
    chk(core_clk_en, 1);
    for (i = 0; i < 2; i++) begin
      if (i == 0) apb(1, 8'h00, 32'h00000001);
      else begin
        watchdog_reset <= 1;
        tick(1);
        watchdog_reset <= 0;
      end
      tick(3);
      chk({extended_por_n, core_reset_n}, 2'h2);
      wait_core;
    end
    apb(0, 8'h00, 32'h0);
    chk(rd[0], 0);
    m = 0;
    repeat (40) begin
      tick(1);
      m += (system_bus_clk_en === 1);
    end
    chk(m, 10);
    for (n = 0; watchdog_tick !== 1 && n < 5000; n++) tick(1);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (watchdog_tick !== 1 && n < 5000);
    chk(n, 4096);
    stop_test;
  end
endmodule : tb
